// File: rtl/curtain_pkg.sv
// Purpose: Shared constants and types for the curtain output supervisor
// Assumes: 10 MHz core clock, 32-bit register port
// Notes: Timing counts derive from the times in their own units
package curtain_pkg;
  // Clock rate and derived ticks
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_CYCLES = CLK_HZ / 1000;
  // Reaction delay from beam or input change to output change
  localparam int RESP_TIME_US = 7000;
  localparam int RESP_CYCLES = RESP_TIME_US * (CLK_HZ / 1_000_000);
  // Relay feedback window and indicator blink half period
  localparam int EDM_WINDOW_MS = 300;
  localparam int BLINK_HALF_MS = 250;
  localparam int WIN_W = 10;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_EDM_WIN = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  // Control field positions
  localparam int CTRL_AUX_LSB = 0;
  localparam int CTRL_IND_LSB = 2;
  localparam int CTRL_EDM_EN_BIT = 4;
  // Status field positions
  localparam int ST_CH1_BIT = 0;
  localparam int ST_CH2_BIT = 1;
  localparam int ST_AUX_BIT = 2;
  localparam int ST_LOCK_BIT = 3;
  localparam int ST_SAFE_IN_BIT = 4;
  localparam int ST_EDM_BIT = 5;
  localparam int ST_DIAG_BIT = 6;
  localparam int ST_TEST_BIT = 7;
  localparam int ST_RED_BIT = 8;
  localparam int ST_GREEN_BIT = 9;
  // Values after reset
  localparam logic RESET_EDM_EN = 1'b1;
  localparam logic [WIN_W-1:0] RESET_EDM_WIN = 10'h12C;
  // Auxiliary output behaviour
  typedef enum logic [1:0] {AUX_INVERSE, AUX_DIRECT, AUX_LOCKOUT} aux_mode_t;
  // Indicator behaviour
  typedef enum logic [1:0] {IND_STEADY, IND_BLINK, IND_OFF} ind_mode_t;
endpackage

// File: rtl/edm_if.sv
// Purpose: Carrier between supervisor and external device monitor
// Assumes: Single core clock domain
// Notes: Feedback is compared against the level it is expected to show
`timescale 1ns/1ps
interface edm_if;
  import curtain_pkg::*;
  logic enable; // Monitoring switched on
  logic ms_tick; // One pulse per millisecond
  logic [WIN_W-1:0] window_ms; // Allowed settle time
  logic expected; // Level the feedback must show
  logic feedback; // Relay feedback contact, synchronous
  logic fault; // Sticky mismatch verdict
  modport sup (output enable, ms_tick, window_ms, expected, feedback, input fault);
  modport mon (input enable, ms_tick, window_ms, expected, feedback, output fault);
endinterface

// File: rtl/edm_monitor.sv
// Purpose: Relay feedback checker against the safety outputs
// Assumes: ms_tick from the supervisor prescaler
// Notes: Resolution is one millisecond; fault holds until reset
`timescale 1ns/1ps
module edm_monitor
  import curtain_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  edm_if.mon edm
);
  // All monitor state
  typedef struct packed {
    logic [WIN_W-1:0] cnt; // Milliseconds of mismatch so far
    logic fault; // Latched verdict
  } mon_state_t;

  mon_state_t mon_reg;
  mon_state_t mon_next;
  logic mismatch; // Feedback disagrees with outputs
  logic [WIN_W-1:0] limit; // Window, never below one ms

  // Next-state logic
  always_comb begin
    mon_next = mon_reg;
    mismatch = edm.enable && (edm.feedback != edm.expected);
    limit = (edm.window_ms == '0) ? WIN_W'(1) : edm.window_ms;
    if (!mismatch) begin
      // Agreement restarts the window for the next change
      mon_next.cnt = '0;
    end else if (edm.ms_tick && !mon_reg.fault) begin
      // Welded or slow relay: mismatch outlasting the window
      if (mon_reg.cnt >= limit - WIN_W'(1)) begin
        mon_next.fault = 1'b1;
      end else begin
        mon_next.cnt = mon_reg.cnt + WIN_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mon_reg <= '0;
    end else begin
      mon_reg <= mon_next;
    end
  end

  assign edm.fault = mon_reg.fault;
endmodule

// File: rtl/curtain_output_supervisor.sv
// Purpose: Safety output supervisor for a light curtain unit
// Assumes: All pin inputs synchronous to core_clk, active high
// Notes: Lockout clears only through reset, standing in for power cycle
//
// Overview of operation
// - Each unit adds its own 7 ms delay
// - Shorted input channel active, open inactive
// - Indicator inputs active light, open stays off
// - Input one from aux shows red
// - Input two from aux shows green
// - Input one from muting lamp shows red
// - Indicator mode: steady, blinking or off
// - Aux output defaults to inverse of outputs
// - Aux output behaviour is reconfigurable
// - Feedback mismatch locks out, outputs off
// - Feedback slower than 300 ms locks out
// - Monitor can be disabled, window adjustable
// - Safety input off forces outputs off
// - Self-diagnosis fault locks out immediately
//
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module curtain_output_supervisor
  import curtain_pkg::*;
#(
  parameter int RESP_COUNT = RESP_CYCLES,
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic beam_received,
  input wire logic test_active,
  input wire logic diag_fault,
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  input wire logic edm_feedback,
  input wire logic ind_in1_active,
  input wire logic ind_in2_active,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic safety_output_ch1,
  output logic safety_output_ch2,
  output logic aux_output,
  output logic indicator_red,
  output logic indicator_green,
  output logic lockout
);
  // Settle and prescaler widths follow the parameters so short values simulate fast; blink width follows BLINK_HALF_MS
  localparam int RESP_W = $clog2(RESP_COUNT + 1);
  localparam int MS_W = $clog2(MS_COUNT + 1);
  localparam int BLINK_W = $clog2(BLINK_HALF_MS + 1);

  // All supervisor state in one record
  typedef struct packed {
    logic [RESP_W-1:0] resp_cnt; // Cycles the request has differed
    logic [MS_W-1:0] ms_cnt; // Millisecond prescaler
    logic [BLINK_W-1:0] blink_cnt; // Milliseconds in blink phase
    logic blink_phase; // Blink lamp phase
    logic out_on; // Settled output decision
    logic out_ch1; // First safety channel
    logic out_ch2; // Second safety channel
    logic aux; // Auxiliary output
    logic lockout; // Latched lockout
    logic cause_diag; // Lockout came from self-diagnosis
    logic cause_edm; // Lockout came from relay monitor
    logic [1:0] aux_mode; // Auxiliary behaviour field
    logic [1:0] ind_mode; // Indicator behaviour field
    logic edm_en; // Relay monitor switched on
    logic [WIN_W-1:0] edm_win; // Relay settle window in ms
    logic red; // Red lamp drive
    logic green; // Green lamp drive
    logic [31:0] rdata; // Read data, valid one cycle
  } sup_state_t;

  sup_state_t state_reg;
  sup_state_t state_next;

  // Combinational helpers
  logic safe_in_on; // Cascaded safety input judged on
  logic request_on; // Outputs wanted on
  logic ms_tick; // Prescaler wrap
  logic edm_fault; // Monitor verdict
  logic trip; // New lockout cause this cycle
  logic lamp_on; // Indicator allowed to light now
  aux_mode_t aux_sel; // Decoded aux mode
  ind_mode_t ind_sel; // Decoded indicator mode
  logic [31:0] status_word; // Status register image

  // Monitor link
  edm_if edm ();

  // Drive the monitor from the registered outputs
  assign edm.enable = state_reg.edm_en;
  assign edm.ms_tick = ms_tick;
  assign edm.window_ms = state_reg.edm_win;
  // Relay feedback contact closes while the relay is released
  assign edm.expected = ~state_reg.out_on;
  assign edm.feedback = edm_feedback;
  assign edm_fault = edm.fault;

  // Relay feedback checker
  edm_monitor u_edm (
    .core_clk(core_clk),
    .reset(reset),
    .edm(edm)
  );

  // Status image built from live state
  always_comb begin
    status_word = '0;
    status_word[ST_CH1_BIT] = state_reg.out_ch1;
    status_word[ST_CH2_BIT] = state_reg.out_ch2;
    status_word[ST_AUX_BIT] = state_reg.aux;
    status_word[ST_LOCK_BIT] = state_reg.lockout;
    status_word[ST_SAFE_IN_BIT] = safe_in_on;
    status_word[ST_EDM_BIT] = state_reg.cause_edm;
    status_word[ST_DIAG_BIT] = state_reg.cause_diag;
    status_word[ST_TEST_BIT] = test_active;
    status_word[ST_RED_BIT] = state_reg.red;
    status_word[ST_GREEN_BIT] = state_reg.green;
  end

  // Next-state logic for the whole block
  always_comb begin
    state_next = state_reg;

    // Millisecond prescaler shared with the monitor and blinker
    ms_tick = (state_reg.ms_cnt == MS_W'(MS_COUNT - 1));
    if (ms_tick) begin
      state_next.ms_cnt = '0;
    end else begin
      state_next.ms_cnt = state_reg.ms_cnt + MS_W'(1);
    end

    // A single open channel counts as off; the input pins are high
    // when their channel is shorted
    safe_in_on = safety_in_ch1 && safety_in_ch2;

    // Outputs wanted on only with beam, upstream on, no test, no lockout
    request_on = beam_received && safe_in_on && !test_active && !state_reg.lockout;

    // Lockout causes; diagnosis acts in the same cycle
    trip = diag_fault || edm_fault;
    if (diag_fault) begin
      state_next.cause_diag = 1'b1;
    end
    if (edm_fault) begin
      state_next.cause_edm = 1'b1;
    end
    if (trip) begin
      // Held until reset; nothing in logic clears it
      state_next.lockout = 1'b1;
    end

    // Output settling: a change is applied after the reaction delay,
    // so cascaded units add their delays
    if (trip || state_reg.lockout) begin
      // Lockout bypasses the delay so outputs drop at once
      state_next.out_on = 1'b0;
      state_next.resp_cnt = '0;
    end else if (request_on == state_reg.out_on) begin
      // Nothing pending
      state_next.resp_cnt = '0;
    end else if (state_reg.resp_cnt == RESP_W'(RESP_COUNT - 1)) begin
      // Delay served, take the new level
      state_next.out_on = request_on;
      state_next.resp_cnt = '0;
    end else begin
      // Still waiting out the reaction delay
      state_next.resp_cnt = state_reg.resp_cnt + RESP_W'(1);
    end

    // Both channels follow one decision; lockout forces both off
    state_next.out_ch1 = state_next.out_on;
    state_next.out_ch2 = state_next.out_on;

    // Auxiliary output per selected behaviour
    aux_sel = aux_mode_t'(state_reg.aux_mode);
    case (aux_sel)
      AUX_INVERSE: begin
        // On in test, blocked beam and lockout, off with beam
        state_next.aux = ~state_next.out_on;
      end
      AUX_DIRECT: begin
        // Follows the safety outputs
        state_next.aux = state_next.out_on;
      end
      AUX_LOCKOUT: begin
        // Flags lockout only
        state_next.aux = state_next.lockout;
      end
      default: begin
        // Unused code falls back to the safe inverse form
        state_next.aux = ~state_next.out_on;
      end
    endcase

    // Blink phase toggles every half period
    if (ms_tick) begin
      if (state_reg.blink_cnt == BLINK_W'(BLINK_HALF_MS - 1)) begin
        state_next.blink_cnt = '0;
        state_next.blink_phase = ~state_reg.blink_phase;
      end else begin
        state_next.blink_cnt = state_reg.blink_cnt + BLINK_W'(1);
      end
    end

    // Indicator mode gates both lamps
    ind_sel = ind_mode_t'(state_reg.ind_mode);
    case (ind_sel)
      IND_STEADY: begin
        lamp_on = 1'b1;
      end
      IND_BLINK: begin
        lamp_on = state_reg.blink_phase;
      end
      IND_OFF: begin
        lamp_on = 1'b0;
      end
      default: begin
        // Unused code keeps the lamp dark
        lamp_on = 1'b0;
      end
    endcase

    // Input one lights red, input two green, whatever drives them:
    // aux output or muting lamp wired back
    state_next.red = ind_in1_active && lamp_on;
    state_next.green = ind_in2_active && lamp_on;

    // Register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: begin
          // Behaviour of aux, lamp and monitor
          state_next.aux_mode = reg_wdata[CTRL_AUX_LSB +: 2];
          state_next.ind_mode = reg_wdata[CTRL_IND_LSB +: 2];
          state_next.edm_en = reg_wdata[CTRL_EDM_EN_BIT];
        end
        ADDR_EDM_WIN: begin
          // Adjustable feedback window
          state_next.edm_win = reg_wdata[WIN_W-1:0];
        end
        default: begin
          // Status and unmapped offsets ignore writes
        end
      endcase
    end

    // Register reads land one cycle later, zero otherwise
    state_next.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: begin
          state_next.rdata[CTRL_AUX_LSB +: 2] = state_reg.aux_mode;
          state_next.rdata[CTRL_IND_LSB +: 2] = state_reg.ind_mode;
          state_next.rdata[CTRL_EDM_EN_BIT] = state_reg.edm_en;
        end
        ADDR_EDM_WIN: begin
          state_next.rdata[WIN_W-1:0] = state_reg.edm_win;
        end
        ADDR_STATUS: begin
          state_next.rdata = status_word;
        end
        default: begin
          // Unmapped reads return zero
          state_next.rdata = '0;
        end
      endcase
    end
  end

  // State register; reset leaves outputs off and aux on
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.aux <= 1'b1;
      state_reg.edm_en <= RESET_EDM_EN;
      state_reg.edm_win <= RESET_EDM_WIN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flip-flops
  assign safety_output_ch1 = state_reg.out_ch1;
  assign safety_output_ch2 = state_reg.out_ch2;
  assign aux_output = state_reg.aux;
  assign indicator_red = state_reg.red;
  assign indicator_green = state_reg.green;
  assign lockout = state_reg.lockout;
  assign reg_rdata = state_reg.rdata;
endmodule

// File: verif/curtain_output_supervisor_checker.sv
// Purpose: Port-level checks for the curtain output supervisor
// Assumes: Control fields are shadowed from the write strobe
// Notes: Settle counters mirror the request the design must see
`timescale 1ns/1ps
module curtain_output_supervisor_checker
  import curtain_pkg::*;
#(
  parameter int RESP_COUNT = RESP_CYCLES,
  parameter int MS_COUNT = MS_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic beam_received,
  input wire logic test_active,
  input wire logic diag_fault,
  input wire logic safety_in_ch1,
  input wire logic safety_in_ch2,
  input wire logic edm_feedback,
  input wire logic ind_in1_active,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic safety_output_ch1,
  input wire logic safety_output_ch2,
  input wire logic aux_output,
  input wire logic indicator_red,
  input wire logic indicator_green,
  input wire logic lockout
);
  logic req; // Outputs are asked to be on
  logic [15:0] on_run; // Cycles the request has stood on
  logic [15:0] off_run; // Cycles the request has stood off
  logic [1:0] aux_mode, aux_prev; // Aux field, now and one cycle ago
  logic [1:0] lamp_mode, lamp_prev; // Lamp field, now and one cycle ago
  logic edm_en; // Monitor switch
  assign req = beam_received & safety_in_ch1 & safety_in_ch2 & !test_active & !lockout;
  // Counters and shadows; the prev copies hide the one-cycle lag after a write
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      on_run <= 16'h0000;
      off_run <= 16'h0000;
      aux_mode <= 2'h0;
      aux_prev <= 2'h0;
      lamp_mode <= 2'h0;
      lamp_prev <= 2'h0;
      edm_en <= RESET_EDM_EN;
    end else begin
      on_run <= req ? on_run + 16'h0001 : 16'h0000;
      off_run <= req ? 16'h0000 : off_run + 16'h0001;
      aux_prev <= aux_mode;
      lamp_prev <= lamp_mode;
      if (reg_wr && reg_addr == ADDR_CTRL) begin
        aux_mode <= reg_wdata[CTRL_AUX_LSB +: 2];
        lamp_mode <= reg_wdata[CTRL_IND_LSB +: 2];
        edm_en <= reg_wdata[CTRL_EDM_EN_BIT];
      end
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_ON_DELAY: assert property ($rose(safety_output_ch1) |-> on_run == RESP_COUNT)
    else $error("outputs rose off the settle count");
  AST_ON_REACH: assert property (on_run == RESP_COUNT && !lockout |-> safety_output_ch1)
    else $error("outputs stayed off after a settled request");
  AST_OFF_DELAY: assert property ($fell(safety_output_ch1) && !lockout |->
    off_run == RESP_COUNT)
    else $error("outputs fell off the settle count");
  AST_CH_PAIR: assert property (safety_output_ch1 == safety_output_ch2)
    else $error("safety channels disagree");
  AST_LOCK_HOLD: assert property (lockout |=> lockout && !safety_output_ch1 && !safety_output_ch2)
    else $error("lockout released or outputs on");
  AST_DIAG: assert property (diag_fault |=> lockout && !safety_output_ch1)
    else $error("diagnosis fault did not lock out");
  AST_AUX_INV: assert property (aux_mode == 2'h0 && aux_prev == 2'h0 |->
    aux_output == !safety_output_ch1)
    else $error("aux not inverse of outputs");
  AST_AUX_DIRECT: assert property (aux_mode == 2'h1 && aux_prev == 2'h1 |->
    aux_output == safety_output_ch1)
    else $error("aux not following outputs");
  AST_LAMP: assert property (lamp_mode == 2'h0 && lamp_prev == 2'h0 && !$past(reset) |->
    indicator_red == $past(ind_in1_active))
    else $error("red lamp not following its input");
  AST_LAMP_OFF: assert property (lamp_mode[1] && lamp_prev[1] |-> !indicator_red && !indicator_green)
    else $error("lamp lit in off mode");
  AST_LOCK_CAUSE: assert property ($rose(lockout) |-> $past(diag_fault) ||
    (edm_en && $past(edm_feedback, 2) == $past(safety_output_ch1, 2)))
    else $error("lockout without a cause");
endmodule

// File: verif/relay_model.sv
// Purpose: Downstream safety relay with its feedback contact
// Assumes: Feedback contact is closed while the coil is off
// Notes: Welded contacts freeze the feedback where it stands
`timescale 1ns/1ps
module relay_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic coil, // Safety output driving the relay
  input wire logic welded, // Contacts stuck
  input wire logic [7:0] lag, // Settle time in cycles
  output logic feedback // Contact seen by the monitor
);
  logic [7:0] wait_reg; // Cycles spent moving
  // Contact settles to the inverse of the coil lag plus one cycles after the coil changes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wait_reg <= 8'h00;
      feedback <= 1'b1;
    end else if (welded || feedback == !coil) begin
      wait_reg <= 8'h00;
    end else if (wait_reg >= lag) begin
      feedback <= !coil;
      wait_reg <= 8'h00;
    end else begin
      wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule

// File: verif/test_curtain_output_supervisor.sv
// Purpose: Self-checking bench for the curtain output supervisor
// Assumes: Shortened counts, 8 cycles settle and 4 cycles per ms
// Notes: Pins are driven by non-blocking assignment at rising edges
`timescale 1ns/1ps
module test_curtain_output_supervisor;
  import curtain_pkg::*;
  localparam int RC = 8; // Shortened settle count
  localparam int MC = 4; // Cycles per millisecond
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic beam_received = 1'b0, test_active = 1'b0, diag_fault = 1'b0;
  logic safety_in_ch1 = 1'b0, safety_in_ch2 = 1'b0;
  logic ind_in1_active = 1'b0, ind_in2_active = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic safety_output_ch1, safety_output_ch2, aux_output;
  logic indicator_red, indicator_green, lockout;
  logic edm_feedback, relay_fb;
  logic welded = 1'b0, loop_back = 1'b0, ind_follow = 1'b0, ind_sel = 1'b0;
  logic [7:0] lag = 8'h03; // Prompt relay by default
  int bad_count = 0;
  int cmp_count = 0;
  // Monitor input looped to aux leaves aux with no other load
  assign edm_feedback = loop_back ? aux_output : relay_fb;
  curtain_output_supervisor #(.RESP_COUNT(RC), .MS_COUNT(MC)) i_dut (.*);
  relay_model i_relay (.core_clk(core_clk), .reset(reset), .coil(safety_output_ch1),
    .welded(welded), .lag(lag), .feedback(relay_fb));
  initial forever #50 core_clk = ~core_clk;
  // Indicator inputs wired to the aux output on request
  always @(posedge core_clk) begin
    if (ind_follow) begin
      ind_in1_active <= aux_output & !ind_sel;
      ind_in2_active <= aux_output & ind_sel;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Bounded wait for a level; a hang counts as a mismatch
  task automatic wait_on(ref logic sig, input logic lvl, output int n);
    n = 0;
    while (sig !== lvl) begin
      tick(1);
      n++;
      if (n > 3000) begin
        bad_count++;
        complete_run();
      end
    end
  endtask
  task automatic reset_dut();
    @(posedge core_clk);
    reset <= 1'b1;
    welded <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    check("reg_rdata", reg_rdata, exp);
  endtask
  // Bits: beam, channel 1, channel 2, test idle; each channel has its own bit
  task automatic drive(input logic [3:0] v);
    @(posedge core_clk);
    beam_received <= v[3];
    safety_in_ch1 <= v[2];
    safety_in_ch2 <= v[1];
    test_active <= !v[0];
  endtask
  task automatic sc_reset_values();
    rd(ADDR_CTRL, 32'h10);
    rd(ADDR_EDM_WIN, 32'h12C);
    rd(ADDR_STATUS, 32'h4);
    rd(8'h0C, 32'h0);
    wr(ADDR_STATUS, 32'hFF);
    rd(ADDR_STATUS, 32'h4);
  endtask
  task automatic sc_gate();
    int n;
    logic [3:0] cut [4] = '{4'h7, 4'hB, 4'hD, 4'hE};
    drive(4'hB);
    tick(RC + 4);
    check("one channel", safety_output_ch1, 1'b0);
    drive(4'hF);
    wait_on(safety_output_ch1, 1'b1, n);
    check("on delay", n, RC);
    check("aux off", aux_output, 1'b0);
    drive(4'h7);
    tick(RC - 2);
    drive(4'hF);
    tick(RC + 2);
    check("short drop", safety_output_ch1, 1'b1);
    foreach (cut[i]) begin
      drive(cut[i]);
      wait_on(safety_output_ch1, 1'b0, n);
      check("off delay", n, RC);
      check("aux on", aux_output, 1'b1);
      drive(4'hF);
      wait_on(safety_output_ch1, 1'b1, n);
    end
  endtask
  task automatic sc_aux_lamp();
    int n;
    int hi;
    wr(ADDR_CTRL, 32'h11);
    tick(2);
    check("aux direct", aux_output, 1'b1);
    wr(ADDR_CTRL, 32'h13);
    tick(2);
    check("aux spare code", aux_output, 1'b0);
    wr(ADDR_CTRL, 32'h12);
    tick(2);
    check("aux lock flag", aux_output, 1'b0);
    wr(ADDR_CTRL, 32'h10);
    ind_follow = 1'b1;
    for (int s = 0; s < 4; s++) begin
      ind_sel = s[0];
      drive(s[1] ? 4'h7 : 4'hF);
      wait_on(safety_output_ch1, !s[1], n);
      tick(3);
      check("red", indicator_red, s[1] & !s[0]);
      check("green", indicator_green, s[1] & s[0]);
    end
    ind_follow = 1'b0;
    wr(ADDR_CTRL, 32'h14);
    hi = 0;
    for (int i = 0; i < 500 * MC; i++) begin
      tick(1);
      hi += (indicator_green === 1'b1);
    end
    check("blink on time", hi, 250 * MC);
    wr(ADDR_CTRL, 32'h18);
    tick(3);
    check("lamp off", indicator_green, 1'b0);
    wr(ADDR_CTRL, 32'h1C);
    tick(3);
    check("lamp spare code", indicator_green, 1'b0);
    ind_in2_active <= 1'b0;
    wr(ADDR_CTRL, 32'h10);
  endtask
  // Window of 5 ms: trip between 4 and 5 ms of mismatch, plus latency
  task automatic sc_monitor();
    int n;
    loop_back <= 1'b1;
    drive(4'hF);
    wait_on(safety_output_ch1, 1'b1, n);
    loop_back <= 1'b0;
    lag <= 8'h0A;
    drive(4'h7);
    tick(RC + 40);
    check("prompt relay", lockout, 1'b0);
    wr(ADDR_CTRL, 32'h00);
    welded <= 1'b1;
    drive(4'hF);
    tick(RC + 40);
    check("monitor off", lockout, 1'b0);
    wr(ADDR_CTRL, 32'h10);
    wait_on(lockout, 1'b1, n);
    check("weld trip", n >= 4 * MC - 1 && n <= 5 * MC + 3, 1'b1);
    rd(ADDR_STATUS, 32'h3C);
    drive(4'h7);
    drive(4'hF);
    tick(RC + 4);
    check("held off", {safety_output_ch1, aux_output}, 2'b01);
    reset_dut();
    wr(ADDR_EDM_WIN, 32'h5);
    lag <= 8'h28;
    wait_on(safety_output_ch1, 1'b1, n);
    wait_on(lockout, 1'b1, n);
    check("slow trip", n >= 4 * MC - 1 && n <= 5 * MC + 3, 1'b1);
    reset_dut();
    lag <= 8'h03;
  endtask
  task automatic sc_diag();
    int n;
    wait_on(safety_output_ch1, 1'b1, n);
    @(posedge core_clk);
    diag_fault <= 1'b1;
    @(posedge core_clk);
    diag_fault <= 1'b0;
    #1;
    check("diag lock", {lockout, safety_output_ch1, aux_output}, 3'b101);
    rd(ADDR_STATUS, 32'h5C);
  endtask
  initial begin
    reset_dut();
    sc_reset_values();
    wr(ADDR_EDM_WIN, 32'h5);
    sc_gate();
    sc_aux_lamp();
    sc_monitor();
    sc_diag();
    complete_run();
  end
endmodule
bind curtain_output_supervisor curtain_output_supervisor_checker
  #(.RESP_COUNT(RESP_COUNT), .MS_COUNT(MS_COUNT)) i_chk (.*);
